// >>> hdl/emp_pkg.sv
// Constants shared by the expansion module port
package emp_pkg;
    localparam logic [7:0] EMP_C1_LOW_BASE  = 8'hC0;
    localparam logic [7:0] EMP_C1_HIGH_BASE = 8'hC8;
    localparam logic [7:0] EMP_C2_LOW_BASE  = 8'hF0;
    localparam logic [7:0] EMP_C2_HIGH_BASE = 8'hF8;
    localparam int         EMP_SEL_SHIFT    = 3;
    localparam int         EMP_CLK_HZ       = 50_000_000;
    localparam int         EMP_MCLK_HZ      = 9_680_000;
    localparam int         EMP_ACC_TIME_NS  = 300;
    localparam int         EMP_ACC_CYC      = (EMP_ACC_TIME_NS * (EMP_CLK_HZ / 1_000_000)
                                               + 999) / 1000;
    localparam logic [7:0] EMP_ACC_CNT      = 8'(EMP_ACC_CYC);
    localparam int         EMP_PHASE_W      = 24;
    localparam logic [EMP_PHASE_W-1:0] EMP_MCLK_INC =
        EMP_PHASE_W'((64'(EMP_MCLK_HZ) << EMP_PHASE_W) / 64'(EMP_CLK_HZ));
    localparam logic [7:0] EMP_DATA_RST     = 8'h00;

    typedef enum logic [4:0] {
        EMP_IDLE   = 5'h01,
        EMP_SETUP  = 5'h02,
        EMP_STROBE = 5'h04,
        EMP_WAIT   = 5'h08,
        EMP_DONE   = 5'h10
    } emp_state_e;
endpackage

// >>> hdl/emp_port.sv
// Host-side expansion module port: two connectors, decode, strobes, wait, irq
// What this block does
// R1: The low select of connector 1 fires for C0-C7 and of connector 2 for F0-F7.
// R2: The high select of connector 1 fires for C8-CF and of connector 2 for F8-FF.
// R3: The three low address bits go out on the module address lines with select and strobe.
// R4: A read is commanded by driving the active-low read strobe to the selected module.
// R5: A write is commanded by driving the active-low write strobe to the selected module.
// R6: Each module gets a reset line that holds it in a defined state while asserted.
// R7: A fitted module pulls its presence line low so the board can see it.
// R8: Both module interrupt lines are routed into the board interrupt matrix.
// R9: While the module holds its wait line low the access is stretched with wait states.
// R10: Each module is supplied with a 9.68 MHz timing clock.
// R11: The two option lines may be enabled as extra interrupt requests.
// R12: Data lines are driven by the board only during write strobes and released otherwise.
`timescale 1ns/1ps
`default_nettype none
module emp_port
    import emp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    // CPU-side I/O request
    input  wire logic       io_req,
    input  wire logic       io_write,
    input  wire logic [7:0] io_addr,
    input  wire logic [7:0] io_wdata,
    output logic            io_ack,
    output logic            io_hit,
    output logic [7:0]      io_rdata,
    input  wire logic       module_reset_req,
    input  wire logic [1:0] option_irq_en,
    output logic [7:0]      irq_matrix,
    output logic [1:0]      present,
    // Shared module pins
    output logic [2:0]      module_addr,
    output logic            io_read_strobe_n,
    output logic            io_write_strobe_n,
    output logic            module_reset,
    output logic            module_clk,
    input  wire logic [7:0] module_data_in,
    output logic [7:0]      module_data_out,
    output logic            module_data_oe_n,
    // Per-connector pins
    output logic [1:0]      module_select_low_n,
    output logic [1:0]      module_select_high_n,
    input  wire logic [1:0] module_wait_n,
    input  wire logic [1:0] module_present_n,
    input  wire logic [3:0] module_irq,
    input  wire logic [3:0] option_lines
);
    emp_state_e       state_ff, nxt_state;
    logic [7:0]       cnt_ff, nxt_cnt;
    logic [7:0]       addr_ff;
    logic             write_ff;
    logic [7:0]       wdata_ff;
    logic [7:0]       rdata_ff;
    logic             ack_ff;
    logic [EMP_PHASE_W-1:0] phase_ff;
    logic             mrst_ff;

    logic [1:0]       wait_s_n;
    logic [1:0]       pres_s_n;
    logic [3:0]       irq_s;
    logic [3:0]       opt_s;
    logic [7:0]       data_s;

    // Pins from the modules cross into this clock here
    emp_sync #(.W(2), .RST(2'h3)) u_sync_wait (
        .clk(clk), .rst_n(rst_n), .d(module_wait_n), .q(wait_s_n));
    emp_sync #(.W(2), .RST(2'h3)) u_sync_pres (
        .clk(clk), .rst_n(rst_n), .d(module_present_n), .q(pres_s_n));
    emp_sync #(.W(4), .RST(4'h0)) u_sync_irq (
        .clk(clk), .rst_n(rst_n), .d(module_irq), .q(irq_s));
    emp_sync #(.W(4), .RST(4'h0)) u_sync_opt (
        .clk(clk), .rst_n(rst_n), .d(option_lines), .q(opt_s));
    emp_sync #(.W(8), .RST(8'h00)) u_sync_data (
        .clk(clk), .rst_n(rst_n), .d(module_data_in), .q(data_s));

    // Address decode: selects on the latched address, hit on the incoming request address
    wire [4:0] blk       = addr_ff[7:EMP_SEL_SHIFT];
    wire       c1_lo     = blk == EMP_C1_LOW_BASE[7:EMP_SEL_SHIFT];   // R1
    wire       c2_lo     = blk == EMP_C2_LOW_BASE[7:EMP_SEL_SHIFT];   // R1
    wire       c1_hi     = blk == EMP_C1_HIGH_BASE[7:EMP_SEL_SHIFT];  // R2
    wire       c2_hi     = blk == EMP_C2_HIGH_BASE[7:EMP_SEL_SHIFT];  // R2
    wire [4:0] req_blk   = io_addr[7:EMP_SEL_SHIFT];
    wire       req_hit   = req_blk == EMP_C1_LOW_BASE[7:EMP_SEL_SHIFT]
                        || req_blk == EMP_C2_LOW_BASE[7:EMP_SEL_SHIFT]
                        || req_blk == EMP_C1_HIGH_BASE[7:EMP_SEL_SHIFT]
                        || req_blk == EMP_C2_HIGH_BASE[7:EMP_SEL_SHIFT];
    wire       conn2     = c2_lo | c2_hi;
    wire       active    = (state_ff != EMP_IDLE);
    wire       strobing  = (state_ff == EMP_STROBE) || (state_ff == EMP_WAIT);
    // Only the addressed connector's wait line may stretch the cycle
    wire       wait_hold = conn2 ? !wait_s_n[1] : !wait_s_n[0];
    wire       cnt_zero  = (cnt_ff == 8'h00);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        unique case (state_ff)
            EMP_IDLE: begin
                if (io_req && req_hit) begin
                    nxt_state = EMP_SETUP;
                end
            end
            EMP_SETUP: begin
                nxt_state = EMP_STROBE;
                nxt_cnt   = EMP_ACC_CNT - 8'h01;
            end
            EMP_STROBE: begin
                if (!cnt_zero) begin
                    nxt_cnt = cnt_ff - 8'h01;
                end else if (wait_hold) begin
                    nxt_state = EMP_WAIT;                     // R9
                end else begin
                    nxt_state = EMP_DONE;
                end
            end
            EMP_WAIT: begin
                if (!wait_hold) begin
                    nxt_state = EMP_DONE;                     // R9
                end
            end
            EMP_DONE: begin
                nxt_state = EMP_IDLE;
            end
            default: begin
                nxt_state = EMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= EMP_IDLE;
            cnt_ff   <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff  <= 8'h00;
            write_ff <= 1'b0;
            wdata_ff <= EMP_DATA_RST;
        end else if (state_ff == EMP_IDLE && io_req) begin
            addr_ff  <= io_addr;
            write_ff <= io_write;
            wdata_ff <= io_wdata;
        end
    end

    // Data is registered as the strobe ends; through the synchroniser it is the pin value from two clk cycles earlier
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= EMP_DATA_RST;
            ack_ff   <= 1'b0;
        end else begin
            ack_ff <= (nxt_state == EMP_DONE) && (state_ff != EMP_DONE);
            if (strobing && nxt_state == EMP_DONE && !write_ff) begin
                rdata_ff <= data_s;                           // R4
            end
        end
    end

    // Phase accumulator gives a 9.68 MHz average rate; jitter is one clk period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= '0;
        end else begin
            phase_ff <= phase_ff + EMP_MCLK_INC;             // R10
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mrst_ff <= 1'b1;
        end else begin
            mrst_ff <= module_reset_req;                      // R6
        end
    end

    // Pin drive
    assign module_clk           = phase_ff[EMP_PHASE_W-1];   // R10
    assign module_reset         = mrst_ff;                    // R6
    assign module_addr          = addr_ff[2:0];               // R3
    assign module_select_low_n  = active ? ~{c2_lo, c1_lo} : 2'h3;  // R1
    assign module_select_high_n = active ? ~{c2_hi, c1_hi} : 2'h3;  // R2
    assign io_read_strobe_n     = !(strobing && !write_ff);   // R4
    assign io_write_strobe_n    = !(strobing && write_ff);    // R5
    assign module_data_out      = wdata_ff;
    assign module_data_oe_n     = !(strobing && write_ff);    // R12

    // Interrupt routing: two module lines plus two option lines per connector
    wire [3:0] opt_gated = opt_s & {option_irq_en[1], option_irq_en[1],
                                    option_irq_en[0], option_irq_en[0]};  // R11
    assign irq_matrix = {opt_gated[3:2], irq_s[3:2], opt_gated[1:0], irq_s[1:0]};  // R8
    assign present    = ~pres_s_n;                            // R7

    // CPU side
    assign io_ack   = ack_ff;
    assign io_hit   = req_hit;
    assign io_rdata = rdata_ff;
endmodule
`default_nettype wire

// >>> hdl/emp_sync.sv
// Two-flop synchroniser for a bundle of external levels
`timescale 1ns/1ps
`default_nettype none
module emp_sync #(
    parameter int          W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RST;
            sync_ff <= RST;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule
`default_nettype wire

// >>> tb/emp_mod_model.sv
// Behavioural plug-in module on both connectors
`timescale 1ns/1ps
`default_nettype none
module emp_mod_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] sel_n,
    input  wire logic [2:0] a,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] d,
    input  wire logic [4:0] slow,
    output logic      [7:0] q,
    output logic      [1:0] wait_n
);
    logic [7:0] mem [32];
    logic [7:0] last = 8'h00;
    logic [4:0] cnt = 5'h00;
    logic [1:0] hit;
    logic [4:0] idx;
    logic       drv;
    assign hit = ~(sel_n[3:2] & sel_n[1:0]);
    assign idx = {hit[1], ~&sel_n[3:2], a};
    assign drv = !rd_n && |hit;
    // Released bus shows the inverse of the last byte so a stale read cannot pass
    assign q = drv ? mem[idx] : ~last;
    assign wait_n = (!(rd_n & wr_n) && cnt < slow) ? ~hit : 2'b11;
    always @(posedge clk) begin
        if (rst) foreach (mem[i]) mem[i] <= 8'h00;
        else if (!wr_n && |hit) mem[idx] <= d;
        cnt <= (rd_n & wr_n) ? 5'h00 : cnt + 5'h01;
        if (drv) last <= mem[idx];
    end
endmodule
`default_nettype wire

// >>> tb/emp_port_props.sv
// Assertion checker for the expansion module port
`timescale 1ns/1ps
`default_nettype none
module emp_port_props (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       io_ack,
    input wire logic [2:0] module_addr,
    input wire logic       io_read_strobe_n,
    input wire logic       io_write_strobe_n,
    input wire logic       module_reset,
    input wire logic       module_reset_req,
    input wire logic       module_data_oe_n,
    input wire logic [1:0] module_select_low_n,
    input wire logic [1:0] module_select_high_n,
    input wire logic [1:0] module_wait_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic       idle;
    logic [1:0] addressed;
    logic [7:0] len_ff;
    assign idle = io_read_strobe_n & io_write_strobe_n;
    assign addressed = ~(module_select_low_n & module_select_high_n);
    // Strobe width exceeds what a repetition may count, so count it here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) len_ff <= 8'h00;
        else len_ff <= idle ? 8'h00 : len_ff + 8'h01;
    end
    property p_sel; !idle |-> $countones({module_select_low_n, module_select_high_n}) == 3;
    endproperty
    a_sel: assert property (p_sel) else $error("select");
    property p_stb; !idle && !$past(idle) |-> $stable(module_addr) && $stable(addressed);
    endproperty
    a_stb: assert property (p_stb) else $error("addr");
    property p_one; io_read_strobe_n || io_write_strobe_n; endproperty
    a_one: assert property (p_one) else $error("strobes");
    property p_oe; module_data_oe_n == io_write_strobe_n; endproperty
    a_oe: assert property (p_oe) else $error("oe");
    property p_rst; $past(rst_n) |-> module_reset == $past(module_reset_req); endproperty
    a_rst: assert property (p_rst) else $error("module_reset");
    property p_len; $rose(idle) |-> len_ff >= 8'h0F; endproperty
    a_len: assert property (p_len) else $error("width");
    property p_wt; (!idle && |(addressed & ~module_wait_n))[*4] |=> !idle; endproperty
    a_wt: assert property (p_wt) else $error("wait");
    property p_ack; $rose(idle) |-> ##[0:2] io_ack; endproperty
    a_ack: assert property (p_ack) else $error("ack");
endmodule
bind emp_port emp_port_props i_props (.*);
`default_nettype wire

// >>> tb/emp_port_tb.sv
// Self-checking bench for the expansion module port
`timescale 1ns/1ps
`default_nettype none
module emp_port_tb;
    logic clk = 1'b0, rst_n = 1'b0, io_req = 1'b0, io_write = 1'b0, module_reset_req = 1'b0;
    logic [7:0] io_addr = 8'h00, io_wdata = 8'h00;
    logic [1:0] option_irq_en = 2'b00, module_present_n = 2'b11;
    logic [3:0] module_irq = 4'h0, option_lines = 4'h0;
    logic [4:0] slow = 5'h00;
    logic io_ack, io_hit, module_reset, module_clk, io_read_strobe_n, io_write_strobe_n;
    logic module_data_oe_n;
    logic [7:0] io_rdata, irq_matrix, module_data_out, module_data_in, md_mod;
    logic [2:0] module_addr;
    logic [1:0] present, module_select_low_n, module_select_high_n, module_wait_n;
    int num_errors = 0, n_checks = 0;
    always #10 clk = ~clk;
    assign module_data_in = module_data_oe_n ? md_mod : module_data_out;
    emp_port i_dut (.*);
    emp_mod_model i_mod (.clk(clk), .rst(module_reset), .a(module_addr), .d(module_data_in),
        .sel_n({module_select_high_n, module_select_low_n}), .rd_n(io_read_strobe_n),
        .wr_n(io_write_strobe_n), .slow(slow), .q(md_mod), .wait_n(module_wait_n));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    // Writes always carry the inverted address, so reads know what to expect
    task automatic acc(input logic w, input logic [7:0] a, output logic [7:0] q, output int ln);
        logic [3:0] es;
        es = 4'hF;
        es[{a[3], a[4]}] = 1'b0;
        @(posedge clk);
        io_req <= 1'b1;
        io_write <= w;
        io_addr <= a;
        io_wdata <= ~a;
        @(posedge clk);
        io_req <= 1'b0;
        for (ln = 0; io_read_strobe_n & io_write_strobe_n && ln < 9; ln++) @(negedge clk);
        chk("pins", {es, a[2:0], w}, {module_select_high_n, module_select_low_n,
            module_addr, io_read_strobe_n});
        chk("wr", {6'h00, ~w, ~w}, {6'h00, module_data_oe_n, io_write_strobe_n});
        for (ln = 0; !(io_read_strobe_n & io_write_strobe_n) && ln < 60; ln++) @(negedge clk);
        for (int n = 0; io_ack !== 1'b1 && n < 5; n++) @(negedge clk);
        chk("ack", 8'h01, {7'h00, io_ack});
        q = io_rdata;
    endtask
    task automatic t_dec;
        logic [7:0] a [8] = '{8'hC0, 8'hC7, 8'hC8, 8'hCF, 8'hF0, 8'hF7, 8'hF8, 8'hFF};
        logic [7:0] q;
        int ln;
        foreach (a[i]) acc(1'b1, a[i], q, ln);
        foreach (a[i]) begin
            acc(1'b0, a[i], q, ln);
            chk("rdata", ~a[i], q);
        end
        chk("len", 8'h0F, 8'(ln));
    endtask
    // An address outside both windows must be refused: no select, no strobe, no ack
    task automatic t_miss;
        logic [7:0] seen;
        seen = 8'h00;
        @(posedge clk);
        io_req <= 1'b1;
        io_write <= 1'b1;
        io_addr <= 8'hD0;
        @(negedge clk);
        chk("hit", 8'h00, {7'h00, io_hit});
        @(posedge clk);
        io_req <= 1'b0;
        io_addr <= 8'hCB;
        @(negedge clk);
        chk("hit", 8'h01, {7'h00, io_hit});
        repeat (20) begin
            @(negedge clk);
            seen |= {io_ack, ~io_read_strobe_n, ~io_write_strobe_n, 1'b0,
                     ~module_select_high_n, ~module_select_low_n};
        end
        chk("miss", 8'h00, seen);
    endtask
    task automatic t_wait;
        logic [7:0] q;
        int ln;
        slow <= 5'h18;
        acc(1'b0, 8'hF8, q, ln);
        chk("waitlen", 8'h01, {7'h00, ln inside {[24:34]}});
        chk("rdata", 8'h07, q);
        slow <= 5'h00;
    endtask
    task automatic t_rst;
        logic [7:0] q;
        int ln;
        @(posedge clk);
        module_reset_req <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk("module_reset", 8'h01, {7'h00, module_reset});
        @(posedge clk);
        module_reset_req <= 1'b0;
        acc(1'b0, 8'hC7, q, ln);
        chk("cleared", 8'h00, q);
    endtask
    task automatic t_irq;
        @(posedge clk);
        module_irq <= 4'h9;
        option_lines <= 4'h6;
        option_irq_en <= 2'b10;
        module_present_n <= 2'b10;
        repeat (4) @(negedge clk);
        chk("irq", 8'h61, irq_matrix);
        chk("present", 8'h01, {6'h00, present});
        @(posedge clk);
        option_irq_en <= 2'b01;
        repeat (4) @(negedge clk);
        chk("irq", 8'h29, irq_matrix);
    endtask
    task automatic t_clk;
        int n = 0;
        logic p;
        p = module_clk;
        repeat (1000) begin
            @(negedge clk);
            n += module_clk & ~p;
            p = module_clk;
        end
        chk("mclk", 8'h01, {7'h00, n inside {[193:194]}});
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_dec;
        t_miss;
        t_wait;
        t_rst;
        t_irq;
        t_clk;
        summarize;
    end
    initial begin
        repeat (8000) @(posedge clk);
        num_errors++;
        summarize;
    end
endmodule
`default_nettype wire
